// *** irq_vec_pkg.sv ***
package irq_vec_pkg;

   // ------------------------------------------------------------
   // Sizes, addresses and reset values
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_GROUPS = 24;
   localparam int NUM_FLAGS = 38;
   localparam logic [15:0] STATUS_BASE = 16'hfe04;
   localparam logic [15:0] STATUS_LAST = 16'hfe07;
   localparam logic [15:0] PIN_CTRL_ADDR = 16'hfe08;
   localparam int STATUS_LSB = 2;
   localparam logic PIN_MASK_RESET = 1'b0;
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_SWI = 16'hfffc;
   localparam logic [15:0] VEC_GROUP1 = 16'hfffa;

   // Source group of every flag; flag 0 is the external pin.
   localparam logic [4:0] FLAG_GROUP [NUM_FLAGS] = '{
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
      5'h09, 5'h09, 5'h09, 5'h0a, 5'h0b, 5'h0b, 5'h0b, 5'h0b,
      5'h0c, 5'h0c, 5'h0d, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11,
      5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h13, 5'h14,
      5'h14, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18};

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef logic [NUM_GROUPS:1] group_t;

   typedef enum logic {ARB_IDLE, ARB_LATCHED} arb_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic take;
      logic software;
      logic resetTake;
      logic saveHigh;
      logic [4:0] group;
      logic [15:0] vector;
      logic [15:0] stackPc;
   } entry_s;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Vector of group g: two bytes below the group above it.
   function automatic logic [15:0] vectorOf(input logic [4:0] g);
      return VEC_GROUP1 - (16'(g - 5'h01) << 1);
   endfunction

   // Lowest numbered request wins; zero means none.
   function automatic logic [4:0] pickGroup(input group_t req);
      logic [4:0] win;
      win = 5'h00;
      for (int g = NUM_GROUPS; g >= 1; g--) begin
         if (req[g]) begin
            win = 5'(g);
         end
      end
      return win;
   endfunction

endpackage

// *** interrupt_priority_vectoring.sv ***
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// Overview of operation
// - Highest-priority pending group is serviced first.
// - Pending request entered right after service return.
// - High index byte never stacked on entry.
// - Software trap interrupts regardless of mask.
// - Software stacks counter; hardware stacks counter-1.
// - Mask blocks all but software trap; reset unmaskable.
// - Reset, software trap priority 0, fixed vectors.
// - Each group has a readable pending flag.
// - Group n priority n, vector FFFA-2(n-1).
// - Groups 1-8: pin, clock, timers.
// - Groups 9-17: serial, keyboard, converter, timebase, wakeup.
// - Groups 18-24: bus controller, timer two channels.
// - Check requests only at instruction boundary.
// - Latched hardware source holds until serviced or unmasked; a latched trap ignores unmasking.
// - Four status bytes at FE04, flag1 bit2.
// - Reset bypasses arbitration, highest priority.
module interrupt_priority_vectoring
   import irq_vec_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic pinRequest,
   input wire logic [NUM_FLAGS-1:1] srcFlags,
   input wire logic [NUM_FLAGS-1:1] srcEnables,
   input wire logic instrDone,
   input wire logic maskBit,
   input wire logic swTrap,
   input wire logic resetReq,
   input wire logic serviceAck,
   input wire logic [15:0] programCounter,
   input wire reg_req_s regReq,
   output logic [DATA_W-1:0] regRdData_q,
   output entry_s entry_q
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic pinMeta_q;
   logic pinSync_q;
   logic pinMask_q;
   logic maskPrev_q;
   group_t flags_q;
   group_t groupReq;
   logic [NUM_FLAGS-1:0] flagVec;
   logic [NUM_FLAGS-1:0] enableVec;
   logic [31:0] statusWord;
   logic [4:0] winner;
   logic hwGo;
   logic swGo;
   logic maskFall;
   arb_e state_q;

   // ------------------------------------------------------------
   // External pin synchroniser
   // ------------------------------------------------------------
   // The pin is asynchronous, so it passes two flops before use.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_q <= 1'b0;
         pinSync_q <= 1'b0;
      end else if (clkEn) begin
         pinMeta_q <= pinRequest;
         pinSync_q <= pinMeta_q;
      end
   end

   // ------------------------------------------------------------
   // Group request formation
   // ------------------------------------------------------------
   // The pin joins the peripheral flags as flag 0, enabled while
   // its software mask bit is clear.
   assign flagVec = {srcFlags, pinSync_q};
   assign enableVec = {srcEnables, ~pinMask_q};

   // Every flag is qualified by its own enable, then ORed into the
   // group that the table assigns it to.
   always_comb begin
      groupReq = '0;
      for (int i = 0; i < NUM_FLAGS; i++) begin
         if (flagVec[i] && enableVec[i]) begin
            groupReq[FLAG_GROUP[i]] = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Pending flags
   // ------------------------------------------------------------
   // Flags mirror the live group levels one cycle late; software
   // reaches them only through the pin mask, which gates flag 1.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else if (clkEn) begin
         flags_q <= groupReq;
      end
   end

   // ------------------------------------------------------------
   // Arbitration
   // ------------------------------------------------------------
   assign winner = pickGroup(groupReq);
   assign maskFall = maskPrev_q && !maskBit;

   // Requests are looked at only when an instruction completes.
   // The return from a service routine is itself such a boundary,
   // so a request still pending is entered before the program
   // resumes.
   assign swGo = instrDone && swTrap;
   assign hwGo = instrDone && !swTrap && !maskBit
      && (winner != 5'h00);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         maskPrev_q <= 1'b0;
      end else if (clkEn) begin
         maskPrev_q <= maskBit;
      end
   end

   // Once latched, a source cannot be displaced by a later one of
   // higher priority; only service, reset or, for a hardware entry, a falling mask free it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ARB_IDLE;
      end else if (clkEn) begin
         if (resetReq) begin
            state_q <= ARB_IDLE;
         end else begin
            case (state_q)
               ARB_IDLE: begin
                  if (swGo || hwGo) begin
                     state_q <= ARB_LATCHED;
                  end
               end
               ARB_LATCHED: begin
                  if (serviceAck) begin
                     state_q <= ARB_IDLE;
                  end else if (maskFall && !entry_q.software) begin
                     state_q <= ARB_IDLE;
                  end
               end
               default: begin
                  state_q <= ARB_IDLE;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Entry request to the core
   // ------------------------------------------------------------
   // Reset takes the vector directly and never competes; the
   // software trap outranks hardware groups at the same boundary.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         entry_q <= '0;
      end else if (clkEn) begin
         entry_q.saveHigh <= 1'b0;
         entry_q.resetTake <= resetReq;
         if (resetReq) begin
            entry_q.take <= 1'b0;
            entry_q.software <= 1'b0;
            entry_q.group <= 5'h00;
            entry_q.vector <= VEC_RESET;
         end else if (state_q == ARB_IDLE && swGo) begin
            entry_q.take <= 1'b1;
            entry_q.software <= 1'b1;
            entry_q.group <= 5'h00;
            entry_q.vector <= VEC_SWI;
            entry_q.stackPc <= programCounter;
         end else if (state_q == ARB_IDLE && hwGo) begin
            entry_q.take <= 1'b1;
            entry_q.software <= 1'b0;
            entry_q.group <= winner;
            entry_q.vector <= vectorOf(winner);
            entry_q.stackPc <= programCounter - 16'h0001;
         end else if (state_q == ARB_LATCHED) begin
            if (serviceAck || (maskFall && !entry_q.software)) begin
               entry_q.take <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   // Flag 1 sits at bit 2 of the first byte; the spare bits read 0.
   assign statusWord = 32'({flags_q, 2'b00});

   // The pin mask is the only writable bit; status bytes ignore
   // writes so a debugger cannot disturb arbitration.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMask_q <= PIN_MASK_RESET;
      end else if (clkEn && regReq.wr) begin
         if (regReq.addr == PIN_CTRL_ADDR) begin
            pinMask_q <= regReq.wdata[0];
         end
      end
   end

   // Read data stand for one cycle; unmapped addresses read zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData_q <= '0;
      end else if (clkEn) begin
         if (!regReq.rd) begin
            regRdData_q <= '0;
         end else if (regReq.addr >= STATUS_BASE
                      && regReq.addr <= STATUS_LAST) begin
            regRdData_q <= statusWord[8*(regReq.addr[1:0])+:8];
         end else if (regReq.addr == PIN_CTRL_ADDR) begin
            regRdData_q <= {7'h00, pinMask_q};
         end else begin
            regRdData_q <= '0;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Properties look at the registered entry one edge after the
   // boundary that caused it. Their antecedents therefore name the
   // inputs as the arbiter saw them, not the outputs.

   sequence s_idleBoundary;
      clkEn && !resetReq && state_q == ARB_IDLE && instrDone;
   endsequence

   sequence s_hwEntry;
      entry_q.take && !entry_q.software;
   endsequence

   // The pin needs three sampled edges before its flag can show,
   // because it passes two flops and then the flag register.
   sequence s_pinHeld;
      (clkEn && pinRequest && !pinMask_q) [*3];
   endsequence

   a_swi_ignores_mask: assert property (
      s_idleBoundary and (swTrap && maskBit) |=>
      entry_q.take && entry_q.vector == VEC_SWI)
      else $error("software trap not taken under mask");

   a_mask_blocks_hw: assert property (
      s_idleBoundary and (maskBit && !swTrap) |=> !entry_q.take)
      else $error("hardware entry taken while masked");

   a_highest_wins: assert property (
      s_idleBoundary and (!maskBit && !swTrap && groupReq != '0)
      |=> s_hwEntry
      ##0 entry_q.vector == vectorOf(pickGroup($past(groupReq))))
      else $error("winning vector is not the highest priority");

   a_latch_holds: assert property (
      clkEn && state_q == ARB_LATCHED && !resetReq && !serviceAck
      && !maskFall |=> $stable(entry_q.vector) && entry_q.take)
      else $error("latched source displaced");

   a_flags_follow: assert property (
      clkEn |=> flags_q == $past(groupReq))
      else $error("pending flags lag the live request");

   a_stack_value: assert property (
      s_idleBoundary and (!swTrap && !maskBit && winner != 5'h00)
      |=> entry_q.stackPc == $past(programCounter) - 16'h0001)
      else $error("hardware entry stacked the wrong counter");

   a_no_high_save: assert property (
      entry_q.take |-> !entry_q.saveHigh)
      else $error("high index byte marked for stacking");

   a_reset_vector: assert property (
      clkEn && resetReq |=> entry_q.resetTake && !entry_q.take
      && entry_q.vector == VEC_RESET && state_q == ARB_IDLE)
      else $error("reset did not bypass arbitration");

   a_status_pad: assert property (
      clkEn && regReq.rd && regReq.addr == STATUS_BASE
      |=> regRdData_q[1:0] == 2'b00
      && regRdData_q[7:2] == $past(flags_q[6:1]))
      else $error("status byte one misplaced");

   a_service_release: assert property (
      clkEn && state_q == ARB_LATCHED && serviceAck && !resetReq
      |=> !entry_q.take && state_q == ARB_IDLE)
      else $error("service acknowledge did not release latch");

   // The trap stacks the counter as it stands, while hardware
   // entries stack one less, so the two cases are checked apart.
   a_trap_stack: assert property (
      s_idleBoundary and swTrap
      |=> entry_q.software && entry_q.stackPc == $past(programCounter))
      else $error("software trap stacked the wrong counter");

   // Without this release a masked routine would leave a stale
   // latch that outranks every later request.
   a_fall_release: assert property (
      clkEn && state_q == ARB_LATCHED && !resetReq && !serviceAck
      && maskFall && !entry_q.software |=> !entry_q.take
      && state_q == ARB_IDLE)
      else $error("falling mask did not free the latch");

   // An entry that started inside an instruction would corrupt the
   // core, so nothing may be latched between boundaries.
   a_only_boundary: assert property (
      clkEn && state_q == ARB_IDLE && !resetReq && !instrDone
      |=> !entry_q.take)
      else $error("entry taken between instruction boundaries");

   a_pin_path: assert property (
      s_pinHeld |=> flags_q[1])
      else $error("held pin request never reached its flag");

   // Flags 8 to 10 share group 9, so one enabled member is enough
   // and a disabled member alone must not raise the group.
   a_group_or: assert property (
      clkEn && srcFlags[8] && srcEnables[8] |=> flags_q[9])
      else $error("enabled member did not raise its group");

   a_enable_gates: assert property (
      clkEn && !srcEnables[8] && srcFlags[10:8] == 3'b001
      |=> !flags_q[9])
      else $error("disabled member raised its group");

   a_status_top: assert property (
      clkEn && regReq.rd && regReq.addr == STATUS_LAST
      |=> regRdData_q == {6'h00, $past(flags_q[24:23])})
      else $error("status byte four misplaced");

endmodule

// *** cpu_core_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Core side of the entry handshake
// ------------------------------------------------------------
module cpu_core_model
   import irq_vec_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire entry_s entry,
   input wire logic [3:0] ackDelay,
   output logic serviceAck
);
   logic [3:0] cnt_q;
   logic acked_q;

   // Acknowledge each entry once, ackDelay+1 cycles after take rises.
   // The routine saves the high index byte itself, nothing stacks it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         acked_q <= 1'b0;
         serviceAck <= 1'b0;
      end else begin
         serviceAck <= 1'b0;
         if (!entry.take) begin
            cnt_q <= 4'h0;
            acked_q <= 1'b0;
         end else if (!acked_q && cnt_q == ackDelay) begin
            serviceAck <= 1'b1;
            acked_q <= 1'b1;
         end else if (!acked_q) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
   import irq_vec_pkg::*;
   logic clk, rst_n, pinRequest, instrDone, maskBit, swTrap, resetReq;
   logic serviceAck;
   logic clkEn;
   logic [NUM_FLAGS-1:1] srcFlags, srcEnables;
   logic [15:0] programCounter;
   logic [3:0] ackDelay;
   reg_req_s regReq;
   logic [DATA_W-1:0] regRdData_q;
   entry_s entry_q;
   int n_fail = 0;
   int check_count = 0;
   // One flag index feeding each of groups 2 to 24.
   int flagOf [2:24] = '{1, 2, 3, 4, 5, 6, 7, 8, 11, 12, 16, 18, 20, 21,
      22, 23, 24, 30, 31, 34, 35, 36, 37};

   interrupt_priority_vectoring dut(.clk(clk), .rst_n(rst_n),
      .clkEn(clkEn), .pinRequest(pinRequest), .srcFlags(srcFlags),
      .srcEnables(srcEnables), .instrDone(instrDone), .maskBit(maskBit),
      .swTrap(swTrap), .resetReq(resetReq), .serviceAck(serviceAck),
      .programCounter(programCounter), .regReq(regReq),
      .regRdData_q(regRdData_q), .entry_q(entry_q));
   cpu_core_model core(.clk(clk), .rst_n(rst_n), .entry(entry_q),
      .ackDelay(ackDelay), .serviceAck(serviceAck));

   // Free running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen,
         input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic regWr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) regReq <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) regReq.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic regRd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk) regReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) regReq.rd <= 1'b0;
      #1 check("read data", 16'(regRdData_q), 16'(e));
   endtask

   task automatic boundary(input logic sw);
      @(posedge clk) begin
         instrDone <= 1'b1;
         swTrap <= sw;
      end
      @(posedge clk) begin
         instrDone <= 1'b0;
         swTrap <= 1'b0;
      end
      #1;
   endtask

   // Bounded wait, since a latch that never drops would hang the run.
   task automatic waitIdle();
      for (int i = 0; i < 40 && entry_q.take !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      check("take dropped", 16'(entry_q.take), 16'h0);
   endtask

   task automatic expectEntry(input logic [4:0] g, input logic [15:0] v,
         input logic [15:0] pc, input logic sw);
      check("take", 16'(entry_q.take), 16'h1);
      check("software", 16'(entry_q.software), 16'(sw));
      check("group", 16'(entry_q.group), 16'(g));
      check("vector", entry_q.vector, v);
      check("stacked pc", entry_q.stackPc, pc);
      check("save high", 16'(entry_q.saveHigh), 16'h0);
      waitIdle();
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_flags();
      regRd(16'hfe04, 8'h00);
      regRd(16'hfe07, 8'h00);
      @(posedge clk) srcFlags <= 37'h1001000082;
      regRd(16'hfe04, 8'h10);
      regRd(16'hfe05, 8'h00);
      regRd(16'hfe06, 8'h08);
      regRd(16'hfe07, 8'h02);
      regWr(16'hfe04, 8'hff);
      regRd(16'hfe04, 8'h10);
      regRd(16'hfe10, 8'h00);
      @(posedge clk) srcEnables <= {NUM_FLAGS-1{1'b1}};
      regRd(16'hfe05, 8'h04);
      @(posedge clk) pinRequest <= 1'b1;
      repeat (3) @(posedge clk);
      regRd(16'hfe04, 8'h14);
      regWr(16'hfe08, 8'h01);
      regRd(16'hfe04, 8'h10);
      regWr(16'hfe08, 8'h00);
      @(posedge clk) pinRequest <= 1'b0;
      $display("flags test done");
   endtask

   // Group 3 latched while group 2 arrives, then 2 and 5 follow.
   task automatic t_priority();
      @(posedge clk) srcFlags <= 37'h000000000a;
      boundary(1'b0);
      @(posedge clk) srcFlags <= 37'h000000000b;
      boundary(1'b0);
      check("no displacement", 16'(entry_q.group), 16'h3);
      expectEntry(5'h03, 16'hfff6, 16'hffff, 1'b0);
      @(posedge clk) ackDelay <= 4'h1;
      boundary(1'b0);
      expectEntry(5'h02, 16'hfff8, 16'hffff, 1'b0);
      @(posedge clk) srcFlags <= 37'h0000000008;
      boundary(1'b0);
      expectEntry(5'h05, 16'hfff2, 16'hffff, 1'b0);
      $display("priority test done");
   endtask

   task automatic t_table();
      logic [NUM_FLAGS-1:1] f;
      @(posedge clk) programCounter <= 16'h8000;
      for (int g = 2; g <= 24; g++) begin
         f = '0;
         f[flagOf[g]] = 1'b1;
         @(posedge clk) srcFlags <= f;
         boundary(1'b0);
         expectEntry(5'(g), 16'hfffa - 16'((g - 1) * 2), 16'h7fff,
            1'b0);
      end
      @(posedge clk) srcFlags <= '0;
      @(posedge clk) pinRequest <= 1'b1;
      repeat (3) @(posedge clk);
      boundary(1'b0);
      expectEntry(5'h01, 16'hfffa, 16'h7fff, 1'b0);
      @(posedge clk) pinRequest <= 1'b0;
      $display("vector table test done");
   endtask

   task automatic t_mask();
      @(posedge clk) begin
         maskBit <= 1'b1;
         srcFlags <= 37'h0000000002;
      end
      boundary(1'b0);
      check("masked take", 16'(entry_q.take), 16'h0);
      boundary(1'b1);
      expectEntry(5'h00, 16'hfffc, 16'h8000, 1'b1);
      @(posedge clk) maskBit <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check("no boundary", 16'(entry_q.take), 16'h0);
      boundary(1'b0);
      expectEntry(5'h03, 16'hfff6, 16'h7fff, 1'b0);
      // A mask that rises and falls again frees a hardware latch.
      @(posedge clk) ackDelay <= 4'h8;
      boundary(1'b0);
      check("latched group", 16'(entry_q.group), 16'h3);
      @(posedge clk) maskBit <= 1'b1;
      @(posedge clk) maskBit <= 1'b0;
      @(posedge clk) #1 check("mask release", 16'(entry_q.take), 16'h0);
      $display("mask test done");
   endtask

   // Reset request overrides a latched entry at once.
   task automatic t_reset();
      @(posedge clk) ackDelay <= 4'h8;
      boundary(1'b0);
      @(posedge clk) resetReq <= 1'b1;
      @(posedge clk) resetReq <= 1'b0;
      #1 check("reset vector", entry_q.vector, 16'hfffe);
      check("reset take", 16'(entry_q.resetTake), 16'h1);
      check("reset drops take", 16'(entry_q.take), 16'h0);
      // A boundary seen while the enable is low must be ignored.
      @(posedge clk) clkEn <= 1'b0;
      boundary(1'b0);
      check("frozen take", 16'(entry_q.take), 16'h0);
      @(posedge clk) clkEn <= 1'b1;
      $display("reset test done");
   endtask

   // Main sequence with reset held for six cycles.
   initial begin
      rst_n = 1'b0;
      pinRequest = 1'b0;
      instrDone = 1'b0;
      maskBit = 1'b0;
      swTrap = 1'b0;
      resetReq = 1'b0;
      clkEn = 1'b1;
      srcFlags = '0;
      srcEnables = 37'h1fffffff7f;
      programCounter = 16'h0000;
      ackDelay = 4'h8;
      regReq = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_flags();
      t_priority();
      t_table();
      t_mask();
      t_reset();
      end_sim();
   end

   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      #100000;
      n_fail++;
      end_sim();
   end
endmodule
